/* File: logic/adcct_params.svh */
`ifndef ADCCT_PARAMS_SVH
`define ADCCT_PARAMS_SVH

// Result format
`define ADCCT_RES_W 10
`define ADCCT_RES_MAX 10'h3FF
`define ADCCT_RES_MIN 10'h000

// Control register upper-nibble field positions
`define ADCCT_CTRL_W 16
`define ADCCT_CTC_HI 15
`define ADCCT_CTC_LO 14
`define ADCCT_STC_HI 13
`define ADCCT_STC_LO 12

// Conversion-time selector codes
`define ADCCT_CTC_BASE 2'h0
`define ADCCT_CTC_UNDEF 2'h1
`define ADCCT_CTC_SLOW 2'h2
`define ADCCT_CTC_MID 2'h3

// Half CPU periods per core_clk cycle
`define ADCCT_UNITS_PER_CLK 12'h002

// Phase lengths in half-CPU-period units
`define ADCCT_SMP_00 {12'h640, 12'h320, 12'h230, 12'h1E0}
`define ADCCT_SMP_11 {12'h320, 12'h190, 12'h118, 12'h0F0}
`define ADCCT_SMP_C0 {12'h190, 12'h0C8, 12'h08C, 12'h078}
`define ADCCT_CMP_00 {12'h460, 12'h460, 12'h460, 12'h3C0}
`define ADCCT_CMP_11 {12'h230, 12'h230, 12'h230, 12'h1E0}
`define ADCCT_CMP_C0 {12'h118, 12'h118, 12'h118, 12'h0F0}
`define ADCCT_EXT_00 {12'h0A4, 12'h0C4, 12'h034, 12'h064}
`define ADCCT_EXT_11 {12'h034, 12'h064, 12'h01C, 12'h034}
`define ADCCT_EXT_C0 {12'h02C, 12'h034, 12'h010, 12'h01C}

`endif

/* File: logic/adcct_pkg.sv */
package adcct_pkg;

    // Sequencer states, one-hot
    typedef enum logic [3:0] {
        ADCCT_IDLE = 4'h1,
        ADCCT_SAMPLE = 4'h2,
        ADCCT_COMPARE = 4'h4,
        ADCCT_EXTRA = 4'h8
    } adcct_state_type;

    // Phase lengths for one selector setting, in units
    typedef struct packed {
        logic [11:0] sample_len;
        logic [11:0] compare_len;
        logic [11:0] extra_len;
    } adcct_timing_type;

    // Conversion result with strobe
    typedef struct packed {
        logic valid;
        logic [9:0] code;
    } adcct_result_type;

endpackage : adcct_pkg

/* File: logic/adcct_timing_lut.sv */
`timescale 1ns/1ps
`include "adcct_params.svh"

module adcct_timing_lut
    import adcct_pkg::*;
(
    input wire logic [1:0] conv_time_select, // Conversion-time selector
    input wire logic [1:0] sample_time_select, // Sample-time selector
    output adcct_timing_type timing // Phase lengths in units
);

    localparam logic [47:0] SMP_BASE = `ADCCT_SMP_C0;
    localparam logic [47:0] SMP_MID = `ADCCT_SMP_11;
    localparam logic [47:0] SMP_SLOW = `ADCCT_SMP_00;
    localparam logic [47:0] CMP_BASE = `ADCCT_CMP_C0;
    localparam logic [47:0] CMP_MID = `ADCCT_CMP_11;
    localparam logic [47:0] CMP_SLOW = `ADCCT_CMP_00;
    localparam logic [47:0] EXT_BASE = `ADCCT_EXT_C0;
    localparam logic [47:0] EXT_MID = `ADCCT_EXT_11;
    localparam logic [47:0] EXT_SLOW = `ADCCT_EXT_00;

    // ------------------------------------------------------------
    // Table lookup
    // ------------------------------------------------------------
    // Undefined selector code falls back to the base row
    always_comb begin
        unique case (conv_time_select)
            `ADCCT_CTC_MID: begin
                timing.sample_len = SMP_MID[sample_time_select*12 +: 12];
                timing.compare_len = CMP_MID[sample_time_select*12 +: 12];
                timing.extra_len = EXT_MID[sample_time_select*12 +: 12];
            end
            `ADCCT_CTC_SLOW: begin
                timing.sample_len = SMP_SLOW[sample_time_select*12 +: 12];
                timing.compare_len = CMP_SLOW[sample_time_select*12 +: 12];
                timing.extra_len = EXT_SLOW[sample_time_select*12 +: 12];
            end
            `ADCCT_CTC_BASE, `ADCCT_CTC_UNDEF: begin
                timing.sample_len = SMP_BASE[sample_time_select*12 +: 12];
                timing.compare_len = CMP_BASE[sample_time_select*12 +: 12];
                timing.extra_len = EXT_BASE[sample_time_select*12 +: 12];
            end
        endcase
    end

endmodule : adcct_timing_lut

/* File: logic/adcct_seq.sv */
`timescale 1ns/1ps
`include "adcct_params.svh"

module adcct_seq
    import adcct_pkg::*;
#(
    parameter int RES_W = `ADCCT_RES_W // Result width
) (
    input wire logic core_clk, // CPU clock
    input wire logic srst, // Synchronous reset, active high
    input wire logic [15:0] converter_control_register, // Control register value
    input wire logic start, // Conversion start pulse
    input wire logic comp_above, // Comparator: input above trial level (pin)
    input wire logic in_below_gnd, // Input below analog ground (pin)
    input wire logic in_above_ref, // Input above reference (pin)
    output logic busy, // Conversion in progress
    output logic sampling, // Sample switch closed
    output logic [RES_W-1:0] trial_code, // Trial code to DAC
    output adcct_result_type result // Result register and done strobe
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    // Whole sequencer state in one struct
    typedef struct packed {
        adcct_state_type st; // Current phase
        logic [11:0] units; // Units elapsed in phase or step
        logic [3:0] bit_idx; // Bit under trial, MSB first
        logic [11:0] step_len; // Units per comparison step
        logic [RES_W-1:0] sar; // Successive-approximation register
        logic [RES_W-1:0] res; // Result register
        logic done; // One-cycle result strobe
        logic [2:0] cmp_s1; // First synchroniser stage
        logic [2:0] cmp_s2; // Second synchroniser stage
        adcct_timing_type tm; // Phase lengths latched at start
    } adcct_regs_type;

    // Registered state and its next value
    adcct_regs_type cur_ff; // Registered state
    adcct_regs_type nxt_cur; // Next state from the decode below

    // Selector fields and the table row they pick
    adcct_timing_type lut_timing; // Table row for present selectors
    logic [1:0] conv_time_select; // Conversion-time selector field
    logic [1:0] sample_time_select; // Sample-time selector field

    // Analog-side flags after synchronisation
    logic comp_sync; // Comparator after two flops
    logic low_sync; // Below-ground flag after two flops
    logic high_sync; // Above-reference flag after two flops

    // Phase timer helpers
    logic [11:0] units_next; // Timer plus one clock worth of units
    logic [11:0] step_total; // Units used by all whole steps
    logic [11:0] extra_limit; // Extra interval plus step remainder
    logic sample_end; // Last cycle of the sample phase
    logic step_end; // Last cycle of a comparison step
    logic extra_end; // Last cycle of the extra interval
    logic last_bit; // Step that decides the LSB
    logic [RES_W-1:0] final_code; // Code bound for the result register

    // ------------------------------------------------------------
    // Selector fields
    // ------------------------------------------------------------
    // Selector fields from the control register upper nibble
    assign conv_time_select = converter_control_register[`ADCCT_CTC_HI:`ADCCT_CTC_LO];
    assign sample_time_select = converter_control_register[`ADCCT_STC_HI:`ADCCT_STC_LO];

    // Phase lengths for the selected setting
    adcct_timing_lut u_lut (
        .conv_time_select(conv_time_select),
        .sample_time_select(sample_time_select),
        .timing(lut_timing)
    );

    // ------------------------------------------------------------
    // Synchronised analog-side flags
    // ------------------------------------------------------------
    // Only the second stage is read; the first may be metastable
    assign comp_sync = cur_ff.cmp_s2[0];
    assign low_sync = cur_ff.cmp_s2[1];
    assign high_sync = cur_ff.cmp_s2[2];

    // ------------------------------------------------------------
    // Phase timer
    // ------------------------------------------------------------
    // Each core_clk cycle spans two half CPU periods
    assign units_next = cur_ff.units + `ADCCT_UNITS_PER_CLK;
    // Whole steps may fall short of the table length
    assign step_total = 12'(cur_ff.step_len * 12'(RES_W));
    // Remainder joins the extra interval so the total stays exact
    assign extra_limit = cur_ff.tm.extra_len + (cur_ff.tm.compare_len - step_total);
    // Phase ends compare against the latched lengths
    assign sample_end = (units_next >= cur_ff.tm.sample_len);
    assign step_end = (units_next >= cur_ff.step_len);
    assign extra_end = (units_next >= extra_limit);
    assign last_bit = (cur_ff.bit_idx == 4'h0);

    // ------------------------------------------------------------
    // Result selection
    // ------------------------------------------------------------
    // Out-of-range flags override the search, above reference first
    assign final_code = high_sync ? `ADCCT_RES_MAX
        : (low_sync ? `ADCCT_RES_MIN : cur_ff.sar);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // Phase sequencing: sample, ten steps, extra, then result
    always_comb begin
        nxt_cur = cur_ff;
        nxt_cur.done = 1'b0;
        // Two-flop synchronisers for analog-side inputs
        nxt_cur.cmp_s1 = {in_above_ref, in_below_gnd, comp_above};
        nxt_cur.cmp_s2 = cur_ff.cmp_s1;
        unique case (cur_ff.st)
            ADCCT_IDLE: begin
                // Start is taken only here; while busy it is ignored
                if (start) begin
                    nxt_cur.tm = lut_timing;
                    nxt_cur.step_len = 12'(lut_timing.compare_len / 12'(RES_W));
                    nxt_cur.units = 12'h000;
                    nxt_cur.st = ADCCT_SAMPLE;
                end
            end
            ADCCT_SAMPLE: begin
                // Sample switch closed while the timer runs
                nxt_cur.units = units_next;
                if (sample_end) begin
                    nxt_cur.units = 12'h000;
                    nxt_cur.bit_idx = 4'(RES_W - 1);
                    nxt_cur.sar = {1'b1, {(RES_W-1){1'b0}}};
                    nxt_cur.st = ADCCT_COMPARE;
                end
            end
            ADCCT_COMPARE: begin
                // One successive-approximation step per result bit
                nxt_cur.units = units_next;
                if (step_end) begin
                    nxt_cur.units = 12'h000;
                    // Trial bit dropped when input is below trial level
                    if (!comp_sync) begin
                        nxt_cur.sar[cur_ff.bit_idx] = 1'b0;
                    end
                    if (last_bit) begin
                        nxt_cur.st = ADCCT_EXTRA;
                    end else begin
                        nxt_cur.bit_idx = cur_ff.bit_idx - 4'h1;
                        nxt_cur.sar[cur_ff.bit_idx - 4'h1] = 1'b1;
                    end
                end
            end
            ADCCT_EXTRA: begin
                // Transfer interval, then load the result register
                nxt_cur.units = units_next;
                if (extra_end) begin
                    nxt_cur.units = 12'h000;
                    nxt_cur.res = final_code;
                    nxt_cur.done = 1'b1;
                    nxt_cur.st = ADCCT_IDLE;
                end
            end
            default: begin
                // Illegal code recovers to idle
                nxt_cur.st = ADCCT_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // Synchronous reset returns every field to a constant
    always_ff @(posedge core_clk) begin
        if (srst) begin
            cur_ff.st <= ADCCT_IDLE;
            cur_ff.units <= 12'h000;
            cur_ff.bit_idx <= 4'h0;
            cur_ff.step_len <= 12'h000;
            cur_ff.sar <= '0;
            cur_ff.res <= '0;
            cur_ff.done <= 1'b0;
            cur_ff.cmp_s1 <= 3'h0;
            cur_ff.cmp_s2 <= 3'h0;
            cur_ff.tm <= '0;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Status decoded from the registered phase
    assign busy = (cur_ff.st != ADCCT_IDLE);
    assign sampling = (cur_ff.st == ADCCT_SAMPLE);
    // Trial code and result straight from flip-flops
    assign trial_code = cur_ff.sar;
    assign result.valid = cur_ff.done;
    assign result.code = cur_ff.res;

endmodule : adcct_seq

/* File: dv/adcct_seq_monitor.sv */
`timescale 1ns/1ps
// ----
// Sequencer checker
// ----
module adcct_seq_monitor
    import adcct_pkg::*;
#(
    parameter int RES_W = 10 // Result width
) (
    input wire logic core_clk, // Clock
    input wire logic srst, // Reset
    input wire logic [15:0] converter_control_register, // Selectors
    input wire logic start, // Start
    input wire logic comp_above, // Comparator
    input wire logic in_below_gnd, // Low clamp
    input wire logic in_above_ref, // High clamp
    input wire logic busy, // Busy
    input wire logic sampling, // Sampling
    input wire logic [RES_W-1:0] trial_code, // Trial code
    input wire adcct_result_type result // Result
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    sequence s_go(logic [3:0] sel);
        start && !busy && converter_control_register[15:12] == sel;
    endsequence
    a_go_busy: assert property (start && !busy |=> busy && sampling)
        else $error("start not taken");
    a_smp_base: assert property (s_go(4'h0) |=> sampling ##59 sampling ##1 !sampling)
        else $error("sample length sel 00");
    a_smp_undef: assert property (s_go(4'h4) |=> sampling ##59 sampling ##1 !sampling)
        else $error("sample length sel 01");
    a_smp_mid: assert property (s_go(4'hC) |=> sampling ##119 sampling ##1 !sampling)
        else $error("sample length sel 11");
    a_smp_slow: assert property (s_go(4'h8) |=> sampling ##239 sampling ##1 !sampling)
        else $error("sample length sel 10");
    a_total_base: assert property (s_go(4'h0) |=> !result.valid [*8] ##[186:188] result.valid)
        else $error("conversion length sel 00");
    a_first_msb: assert property ($fell(sampling) |-> ##[0:1] trial_code == 10'h200)
        else $error("first trial code");
    a_valid_pulse: assert property (result.valid |=> !result.valid)
        else $error("valid too long");
    a_code_hold: assert property (!result.valid |-> $stable(result.code))
        else $error("code changed");
    a_clamp_top: assert property (result.valid && in_above_ref && $past(in_above_ref, 8)
        |-> result.code == 10'h3FF)
        else $error("high clamp");
    a_clamp_zero: assert property (result.valid && !in_above_ref && in_below_gnd
        && $past(in_below_gnd, 8) |-> result.code == 10'h000)
        else $error("low clamp");
endmodule : adcct_seq_monitor

bind adcct_seq adcct_seq_monitor #(.RES_W(RES_W)) i_adcct_seq_monitor (.core_clk(core_clk),
    .srst(srst), .converter_control_register(converter_control_register), .start(start),
    .comp_above(comp_above), .in_below_gnd(in_below_gnd), .in_above_ref(in_above_ref),
    .busy(busy), .sampling(sampling), .trial_code(trial_code), .result(result));

/* File: dv/tb.sv */
`timescale 1ns/1ps
// ----
// Sequencer bench
// ----
module tb;
    import adcct_pkg::*;
    logic core_clk, srst, start, comp_above, in_below_gnd, in_above_ref, busy, sampling;
    logic [15:0] converter_control_register;
    logic [9:0] trial_code, target;
    adcct_result_type result;
    int n_mismatch, check_count;
    int smp_t[4][4] = '{'{120, 140, 200, 400}, '{120, 140, 200, 400},
        '{480, 560, 800, 1600}, '{240, 280, 400, 800}};
    int cmp_t[4][4] = '{'{240, 280, 280, 280}, '{240, 280, 280, 280},
        '{960, 1120, 1120, 1120}, '{480, 560, 560, 560}};
    int ext_t[4][4] = '{'{28, 16, 52, 44}, '{28, 16, 52, 44},
        '{100, 52, 196, 164}, '{52, 28, 100, 52}};

    adcct_seq i_adcct_seq (.core_clk(core_clk), .srst(srst),
        .converter_control_register(converter_control_register), .start(start),
        .comp_above(comp_above), .in_below_gnd(in_below_gnd), .in_above_ref(in_above_ref),
        .busy(busy), .sampling(sampling), .trial_code(trial_code), .result(result));

    // Clock
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // Comparator: analog input sits at target
    always @(posedge core_clk) comp_above <= (target >= trial_code);

    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk

    // One conversion; poke retries start while busy
    task automatic run(logic [3:0] sel, logic [9:0] tgt, logic [9:0] code, int smp, int tot,
        bit poke);
        int n;
        int ns;
        n = 0;
        ns = 0;
        @(posedge core_clk);
        converter_control_register <= {sel, 12'h000};
        start <= 1'b1;
        target <= tgt;
        @(posedge core_clk);
        start <= 1'b0;
        while (result.valid !== 1'b1 && n < 3000) begin
            @(posedge core_clk);
            n++;
            ns += (sampling === 1'b1);
            start <= poke && n == 20;
            if (poke && n == 20) converter_control_register <= 16'hF000;
        end
        chk("sample cycles", smp / 2, ns[15:0]);
        chk("total in window", 1, (n >= tot / 2 && n <= tot / 2 + 2));
        chk("code", code, result.code);
        repeat (3) @(posedge core_clk);
        chk("idle after", 0, busy);
    endtask : run

    // Every selector pair, input at ground
    task automatic t_timing;
        for (int c = 0; c < 4; c++) begin
            for (int s = 0; s < 4; s++) begin
                run({c[1:0], s[1:0]}, 0, 0, smp_t[c][s],
                    smp_t[c][s] + cmp_t[c][s] + ext_t[c][s], 0);
            end
        end
    endtask : t_timing

    // Successive approximation results, one with a refused start
    task automatic t_code;
        run(4'h0, 10'h155, 10'h155, 120, 388, 1);
        run(4'h0, 10'h3FF, 10'h3FF, 120, 388, 0);
        run(4'h3, 10'h2AA, 10'h2AA, 400, 724, 0);
    endtask : t_code

    // Out-of-range inputs clamp
    task automatic t_clamp;
        in_above_ref <= 1'b1;
        run(4'h0, 10'h000, 10'h3FF, 120, 388, 0);
        in_above_ref <= 1'b0;
        in_below_gnd <= 1'b1;
        run(4'h0, 10'h3FF, 10'h000, 120, 388, 0);
        in_below_gnd <= 1'b0;
    endtask : t_clamp

    task automatic final_report;
        $display("mismatches %0d checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : final_report

    // Watchdog
    initial begin
        repeat (20000) @(posedge core_clk);
        n_mismatch++;
        final_report();
    end

    // Main sequence
    initial begin
        srst = 1'b1;
        start = 1'b0;
        comp_above = 1'b0;
        in_below_gnd = 1'b0;
        in_above_ref = 1'b0;
        target = 10'h000;
        converter_control_register = 16'h0000;
        repeat (8) @(posedge core_clk);
        srst <= 1'b0;
        t_timing();
        t_code();
        t_clamp();
        final_report();
    end
endmodule : tb
